/* rtl/psr_top.sv */
// Position scaling, parameter registers and linear ramp profile generator.
// Summary of operation
// - Writing the denominator alone keeps scaling; numerator write adopts the new pair.
// - Numerator is signed 32-bit revolutions, 1 to 2147483647, reset 1.
// - Denominator is signed 32-bit user units, up to 2147483647, reset 16384.
// - Scaling writes are refused while the power amplifier is enabled.
// - User positions convert to internal units while the amplifier is enabled.
// - Internal resolution is 131072 counts per motor revolution.
// - Default 16384 units per revolution gives eight counts per user unit.
// - 4096 units per revolution gives 32 counts per user unit.
// - Conversion may saturate; reduced limits are flagged and applied.
// - Profile follows target position and speed according to the operating mode.
// - Ramps are linear and identical for both movement directions.
// - Acceleration is unsigned 32-bit, 30 to 3000000, reset 600.
// - Deceleration is unsigned 32-bit, 750 to 3000000, reset 750.
// - Speed limit is in 1/min, 60 to 13200, reset 13200.
// - Position, velocity, homing and jog modes clamp target speed to the limit.
`timescale 1ns/100ps
`default_nettype none
module psr_top #(
	parameter int unsigned CTRL_CYCLE_CLK = psr_pkg::CTRL_CYCLE_CLK,
	parameter logic [31:0] APPROACH_WINDOW = psr_pkg::RST_APPROACH
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Fieldbus parameter access
	input  wire logic        par_wr_in,
	input  wire logic        par_rd_in,
	input  wire logic [11:0] par_addr_in,
	input  wire logic [31:0] par_wdata_in,
	output logic [31:0]      par_rdata_out,
	output logic             par_ack_out,
	output logic             par_err_out,
	// Drive state and command
	input  wire logic        amp_enable_in,
	input  wire logic [2:0]  mode_in,
	input  wire logic        start_in,
	input  wire logic [31:0] target_pos_in,
	input  wire logic [31:0] target_speed_in,
	input  wire logic [31:0] actual_pos_in,
	// Profile outputs
	output logic [31:0]      target_int_out,
	output logic             conv_done_out,
	output logic [31:0]      speed_set_out,
	output logic             reached_out,
	output logic             limited_out
);
	// ************************************************************
	// Helper functions
	// ************************************************************
	function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic [31:0] mag32(input logic [31:0] v);
		mag32 = v[31] ? (32'h0000_0000 - v) : v;
	endfunction : mag32

	// ************************************************************
	// Registers
	// ************************************************************
	logic [31:0]        den_reg;
	logic [31:0]        num_reg;
	logic [31:0]        act_num_reg;
	logic [31:0]        act_den_reg;
	logic [31:0]        speed_limit_reg;
	logic [31:0]        acc_reg;
	logic [31:0]        dec_reg;
	logic [31:0]        target_int_reg;
	logic               reached_reg;
	logic               limited_reg;
	logic [31:0]        tick_cnt_reg;
	logic               tick_reg;
	psr_pkg::psr_seq_e  seq_reg;
	logic [31:0]        goal_reg;

	logic        wr_ok;
	logic        wr_scale;
	logic        scaler_done;
	logic        scaler_limited;
	logic [31:0] scaler_result;
	logic [31:0] ramp_speed;
	logic [31:0] speed_mag;
	logic [31:0] clamped_rpm;
	logic [31:0] goal_next;
	logic [31:0] remaining;
	logic        clamp_mode;
	logic        near_target;
	psr_pkg::psr_mode_e mode;

	// ************************************************************
	// Parameter write decode
	// ************************************************************
	always_comb begin
		wr_scale = (par_addr_in == psr_pkg::OFS_SCALE_DEN) ||
			(par_addr_in == psr_pkg::OFS_SCALE_NUM);
		unique case (par_addr_in)
			psr_pkg::OFS_SCALE_DEN: begin
				wr_ok = !amp_enable_in &&
					in_range(par_wdata_in, psr_pkg::MIN_SCALE, psr_pkg::MAX_SCALE);
			end
			psr_pkg::OFS_SCALE_NUM: begin
				wr_ok = !amp_enable_in &&
					in_range(par_wdata_in, psr_pkg::MIN_SCALE, psr_pkg::MAX_SCALE);
			end
			psr_pkg::OFS_SPEED_LIMIT: begin
				wr_ok = in_range(par_wdata_in, psr_pkg::MIN_SPEED_LIMIT,
					psr_pkg::MAX_SPEED_LIMIT);
			end
			psr_pkg::OFS_RAMP_ACC: begin
				wr_ok = in_range(par_wdata_in, psr_pkg::MIN_RAMP_ACC, psr_pkg::MAX_RAMP);
			end
			psr_pkg::OFS_RAMP_DEC: begin
				wr_ok = in_range(par_wdata_in, psr_pkg::MIN_RAMP_DEC, psr_pkg::MAX_RAMP);
			end
			default: begin
				wr_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			den_reg         <= psr_pkg::RST_SCALE_DEN;
			num_reg         <= psr_pkg::RST_SCALE_NUM;
			speed_limit_reg <= psr_pkg::RST_SPEED_LIMIT;
			acc_reg         <= psr_pkg::RST_RAMP_ACC;
			dec_reg         <= psr_pkg::RST_RAMP_DEC;
		end else if (par_wr_in && wr_ok) begin
			unique case (par_addr_in)
				psr_pkg::OFS_SCALE_DEN:   den_reg         <= par_wdata_in;
				psr_pkg::OFS_SCALE_NUM:   num_reg         <= par_wdata_in;
				psr_pkg::OFS_SPEED_LIMIT: speed_limit_reg <= par_wdata_in;
				psr_pkg::OFS_RAMP_ACC:    acc_reg         <= par_wdata_in;
				psr_pkg::OFS_RAMP_DEC:    dec_reg         <= par_wdata_in;
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Active scaling pair
	// ************************************************************
	// A denominator write alone only stages a value, so a half-written ratio never steers motion.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			act_num_reg <= psr_pkg::RST_SCALE_NUM;
			act_den_reg <= psr_pkg::RST_SCALE_DEN;
		end else if (par_wr_in && wr_ok && par_addr_in == psr_pkg::OFS_SCALE_NUM) begin
			act_num_reg <= par_wdata_in;
			act_den_reg <= den_reg;
		end
	end

	// ************************************************************
	// Parameter answer
	// ************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			par_rdata_out <= '0;
			par_ack_out   <= 1'b0;
			par_err_out   <= 1'b0;
		end else begin
			par_ack_out <= par_wr_in || par_rd_in;
			par_err_out <= (par_wr_in && !wr_ok) || (par_rd_in &&
				!(wr_scale || par_addr_in == psr_pkg::OFS_SPEED_LIMIT ||
				par_addr_in == psr_pkg::OFS_RAMP_ACC || par_addr_in == psr_pkg::OFS_RAMP_DEC ||
				par_addr_in == psr_pkg::OFS_STATUS));
			if (par_rd_in) begin
				unique case (par_addr_in)
					psr_pkg::OFS_SCALE_DEN:   par_rdata_out <= den_reg;
					psr_pkg::OFS_SCALE_NUM:   par_rdata_out <= num_reg;
					psr_pkg::OFS_SPEED_LIMIT: par_rdata_out <= speed_limit_reg;
					psr_pkg::OFS_RAMP_ACC:    par_rdata_out <= acc_reg;
					psr_pkg::OFS_RAMP_DEC:    par_rdata_out <= dec_reg;
					psr_pkg::OFS_STATUS: begin
						par_rdata_out <= '0;
						par_rdata_out[psr_pkg::ST_BIT_BUSY]    <= seq_reg != psr_pkg::SEQ_IDLE;
						par_rdata_out[psr_pkg::ST_BIT_REACHED] <= reached_reg;
						par_rdata_out[psr_pkg::ST_BIT_LIMITED] <= limited_reg;
						par_rdata_out[psr_pkg::ST_BIT_AMP]     <= amp_enable_in;
					end
					default: par_rdata_out <= '0;
				endcase
			end
		end
	end

	// ************************************************************
	// Control cycle divider
	// ************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == 32'(CTRL_CYCLE_CLK - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
			tick_reg     <= 1'b0;
		end
	end

	// ************************************************************
	// Position conversion
	// ************************************************************
	psr_scaler u_scaler (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.start_in    (start_in && amp_enable_in && (seq_reg == psr_pkg::SEQ_IDLE ||
			(seq_reg == psr_pkg::SEQ_MOVE && mode != psr_pkg::MODE_PROF_POS))),
		.user_in     (target_pos_in),
		.num_in      (act_num_reg),
		.den_in      (act_den_reg),
		.done_out    (scaler_done),
		.limited_out (scaler_limited),
		.result_out  (scaler_result)
	);

	// ************************************************************
	// Profile goal
	// ************************************************************
	always_comb begin
		mode        = psr_pkg::psr_mode_e'(mode_in);
		speed_mag   = mag32(target_speed_in);
		remaining   = target_int_reg - actual_pos_in;
		near_target = mag32(remaining) <= APPROACH_WINDOW;
		unique case (mode)
			psr_pkg::MODE_PROF_POS, psr_pkg::MODE_PROF_VEL,
			psr_pkg::MODE_HOMING, psr_pkg::MODE_JOG: clamp_mode = 1'b1;
			default:                                 clamp_mode = 1'b0;
		endcase
		clamped_rpm = (clamp_mode && speed_mag > speed_limit_reg) ? speed_limit_reg
			: speed_mag;
		goal_next   = 32'(clamped_rpm * psr_pkg::MRPM_PER_RPM);
		if (seq_reg != psr_pkg::SEQ_MOVE || !amp_enable_in) begin
			goal_next = '0;
		end else if (mode == psr_pkg::MODE_PROF_POS) begin
			if (near_target) begin
				goal_next = '0;
			end else if (remaining[31]) begin
				goal_next = 32'h0000_0000 - goal_next;
			end
		end else if (target_speed_in[31]) begin
			goal_next = 32'h0000_0000 - goal_next;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			goal_reg <= '0;
		end else begin
			goal_reg <= goal_next;
		end
	end

	// One ramp step in milli-rpm per millisecond equals the steepness in rpm per second.
	psr_ramp u_ramp (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.tick_in     (tick_reg),
		.goal_in     (goal_reg),
		.acc_step_in (acc_reg),
		.dec_step_in (dec_reg),
		.speed_out   (ramp_speed)
	);

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			seq_reg        <= psr_pkg::SEQ_IDLE;
			target_int_reg <= '0;
			reached_reg    <= 1'b0;
			limited_reg    <= 1'b0;
		end else begin
			unique case (seq_reg)
				psr_pkg::SEQ_IDLE: begin
					if (start_in && amp_enable_in) begin
						seq_reg     <= psr_pkg::SEQ_CONV;
						reached_reg <= 1'b0;
					end
				end
				psr_pkg::SEQ_CONV: begin
					if (scaler_done) begin
						target_int_reg <= scaler_result;
						limited_reg    <= scaler_limited;
						seq_reg        <= psr_pkg::SEQ_MOVE;
					end
				end
				psr_pkg::SEQ_MOVE: begin
					if (!amp_enable_in && ramp_speed == 32'h0000_0000) begin
						seq_reg <= psr_pkg::SEQ_IDLE;
					end else if (mode == psr_pkg::MODE_PROF_POS && near_target &&
						ramp_speed == 32'h0000_0000) begin
						reached_reg <= 1'b1;
						seq_reg     <= psr_pkg::SEQ_IDLE;
					end else if (mode != psr_pkg::MODE_PROF_POS && start_in && amp_enable_in) begin
						seq_reg <= psr_pkg::SEQ_CONV;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Output stage
	// ************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			target_int_out <= '0;
			conv_done_out  <= 1'b0;
			speed_set_out  <= '0;
			reached_out    <= 1'b0;
			limited_out    <= 1'b0;
		end else begin
			target_int_out <= target_int_reg;
			conv_done_out  <= scaler_done;
			speed_set_out  <= ramp_speed;
			reached_out    <= reached_reg;
			limited_out    <= limited_reg;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence num_write_s;
		par_wr_in && wr_ok && par_addr_in == psr_pkg::OFS_SCALE_NUM;
	endsequence

	den_hold_a: assert property (
		(par_wr_in && par_addr_in == psr_pkg::OFS_SCALE_DEN) |=> $stable(act_den_reg))
		else $error("Active denominator changed on a denominator write.");
	num_adopt_a: assert property (
		num_write_s |=> (act_num_reg == $past(par_wdata_in) && act_den_reg == $past(den_reg)))
		else $error("Numerator write did not adopt the scaling pair.");
	amp_lock_a: assert property (
		(par_wr_in && wr_scale && amp_enable_in) |=> (par_err_out && $stable(num_reg)
		&& $stable(den_reg)))
		else $error("Scaling changed while the amplifier was enabled.");
	num_range_a: assert property (
		(num_reg >= psr_pkg::MIN_SCALE) && (num_reg <= psr_pkg::MAX_SCALE))
		else $error("Numerator left its range.");
	ramp_range_a: assert property (
		(acc_reg >= psr_pkg::MIN_RAMP_ACC) && (dec_reg >= psr_pkg::MIN_RAMP_DEC)
		&& (acc_reg <= psr_pkg::MAX_RAMP))
		else $error("Ramp steepness left its range.");
	speed_clamp_a: assert property (
		(seq_reg == psr_pkg::SEQ_MOVE && clamp_mode) |=>
		(mag32(goal_reg) <= 32'(speed_limit_reg * psr_pkg::MRPM_PER_RPM)))
		else $error("Target speed exceeds the limit.");
	ramp_step_a: assert property (
		tick_reg |=> (mag32(ramp_speed - $past(ramp_speed)) <=
		((acc_reg > dec_reg) ? acc_reg : dec_reg)))
		else $error("Speed changed by more than one ramp step.");
	ramp_hold_a: assert property (
		!tick_reg |=> $stable(ramp_speed))
		else $error("Speed changed outside a control cycle.");
	conv_gate_a: assert property (
		(seq_reg == psr_pkg::SEQ_IDLE && start_in && !amp_enable_in) |=>
		seq_reg == psr_pkg::SEQ_IDLE)
		else $error("Conversion started with the amplifier off.");
	conv_bound_a: assert property (
		(seq_reg == psr_pkg::SEQ_IDLE && start_in && amp_enable_in) |=>
		##[80:84] (conv_done_out || seq_reg != psr_pkg::SEQ_CONV))
		else $error("Conversion did not finish in time.");
endmodule : psr_top
`default_nettype wire

/* rtl/psr_pkg.sv */
// Package with register map, limits, timing and modes of the position scaling and ramp block.
package psr_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [11:0] OFS_SCALE_DEN   = 12'h060E;
	localparam logic [11:0] OFS_SCALE_NUM   = 12'h0610;
	localparam logic [11:0] OFS_SPEED_LIMIT = 12'h0612;
	localparam logic [11:0] OFS_RAMP_ACC    = 12'h0614;
	localparam logic [11:0] OFS_RAMP_DEC    = 12'h0616;
	localparam logic [11:0] OFS_STATUS      = 12'h0618;

	// ************************************************************
	// Reset values and accepted ranges
	// ************************************************************
	localparam logic [31:0] RST_SCALE_DEN   = 32'h0000_4000;
	localparam logic [31:0] RST_SCALE_NUM   = 32'h0000_0001;
	localparam logic [31:0] RST_SPEED_LIMIT = 32'h0000_3390;
	localparam logic [31:0] RST_RAMP_ACC    = 32'h0000_0258;
	localparam logic [31:0] RST_RAMP_DEC    = 32'h0000_02EE;
	localparam logic [31:0] MIN_SCALE       = 32'h0000_0001;
	localparam logic [31:0] MAX_SCALE       = 32'h7FFF_FFFF;
	localparam logic [31:0] MIN_SPEED_LIMIT = 32'h0000_003C;
	localparam logic [31:0] MAX_SPEED_LIMIT = 32'h0000_3390;
	localparam logic [31:0] MIN_RAMP_ACC    = 32'h0000_001E;
	localparam logic [31:0] MIN_RAMP_DEC    = 32'h0000_02EE;
	localparam logic [31:0] MAX_RAMP        = 32'h002D_C6C0;

	// ************************************************************
	// Status field positions
	// ************************************************************
	localparam int ST_BIT_BUSY    = 0;
	localparam int ST_BIT_REACHED = 1;
	localparam int ST_BIT_LIMITED = 2;
	localparam int ST_BIT_AMP     = 3;

	// ************************************************************
	// Resolution and timing
	// ************************************************************
	localparam int          RES_SHIFT      = 17;
	localparam logic [31:0] MRPM_PER_RPM   = 32'h0000_03E8;
	localparam int          CLK_PERIOD_NS  = 4;
	localparam int          CTRL_CYCLE_US  = 1000;
	localparam int          CTRL_CYCLE_CLK = (CTRL_CYCLE_US * 1000) / CLK_PERIOD_NS;
	localparam logic [31:0] RST_APPROACH   = 32'h0000_0010;

	// ************************************************************
	// Operating modes and sequencer states
	// ************************************************************
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_PROF_POS,
		MODE_PROF_VEL,
		MODE_HOMING,
		MODE_JOG,
		MODE_OTHER
	} psr_mode_e;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_CONV,
		SEQ_MOVE
	} psr_seq_e;

endpackage : psr_pkg

/* rtl/psr_scaler.sv */
// Sequential user-to-internal position converter with saturation.
`timescale 1ns/100ps
`default_nettype none
module psr_scaler (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Request
	input  wire logic        start_in,
	input  wire logic [31:0] user_in,
	input  wire logic [31:0] num_in,
	input  wire logic [31:0] den_in,
	// Answer
	output logic             done_out,
	output logic             limited_out,
	output logic [31:0]      result_out
);
	localparam int DW = 80;

	logic [DW-1:0] dividend_reg;
	logic [31:0]   den_reg;
	logic [32:0]   rem_reg;
	logic [6:0]    count_reg;
	logic          neg_reg;
	logic          busy_reg;
	logic [32:0]   rem_shift;
	logic [62:0]   mag_prod;
	logic [31:0]   user_mag;

	always_comb begin
		user_mag  = user_in[31] ? (32'h0000_0000 - user_in) : user_in;
		mag_prod  = 63'(user_mag) * 63'(num_in[30:0]);
		rem_shift = {rem_reg[31:0], dividend_reg[DW-1]};
	end

	// ************************************************************
	// Restoring division of |user|*num*2^17 by den
	// ************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dividend_reg <= '0;
			den_reg      <= '0;
			rem_reg      <= '0;
			count_reg    <= '0;
			neg_reg      <= 1'b0;
			busy_reg     <= 1'b0;
			done_out     <= 1'b0;
			limited_out  <= 1'b0;
			result_out   <= '0;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy_reg) begin
				dividend_reg <= {mag_prod, psr_pkg::RES_SHIFT'(0)};
				den_reg      <= den_in;
				rem_reg      <= '0;
				count_reg    <= 7'(DW);
				neg_reg      <= user_in[31];
				busy_reg     <= 1'b1;
			end else if (busy_reg && count_reg != 7'h00) begin
				count_reg <= count_reg - 7'h01;
				if (rem_shift >= {1'b0, den_reg}) begin
					rem_reg      <= rem_shift - {1'b0, den_reg};
					dividend_reg <= {dividend_reg[DW-2:0], 1'b1};
				end else begin
					rem_reg      <= rem_shift;
					dividend_reg <= {dividend_reg[DW-2:0], 1'b0};
				end
			end else if (busy_reg) begin
				busy_reg <= 1'b0;
				done_out <= 1'b1;
				if (dividend_reg[DW-1:31] != '0) begin
					limited_out <= 1'b1;
					result_out  <= neg_reg ? 32'h8000_0001 : psr_pkg::MAX_SCALE;
				end else begin
					limited_out <= 1'b0;
					result_out  <= neg_reg ? (32'h0000_0000 - dividend_reg[31:0])
						: dividend_reg[31:0];
				end
			end
		end
	end
endmodule : psr_scaler
`default_nettype wire

/* rtl/psr_ramp.sv */
// Linear speed ramp that steps once per control cycle.
`timescale 1ns/100ps
`default_nettype none
module psr_ramp (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Control
	input  wire logic        tick_in,
	input  wire logic [31:0] goal_in,
	input  wire logic [31:0] acc_step_in,
	input  wire logic [31:0] dec_step_in,
	// Setpoint
	output logic [31:0]      speed_out
);
	logic        accel;
	logic [31:0] step;
	logic [31:0] diff;
	logic [31:0] diff_mag;

	always_comb begin
		diff     = goal_in - speed_out;
		diff_mag = diff[31] ? (32'h0000_0000 - diff) : diff;
		// Speeding up away from zero uses the acceleration steepness in either direction.
		accel = (speed_out == 32'h0000_0000) ||
			((goal_in[31] == speed_out[31]) && (diff[31] == speed_out[31]));
		step  = accel ? acc_step_in : dec_step_in;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			speed_out <= '0;
		end else if (tick_in) begin
			if (diff_mag <= step) begin
				speed_out <= goal_in;
			end else if (diff[31]) begin
				speed_out <= speed_out - step;
			end else begin
				speed_out <= speed_out + step;
			end
		end
	end
endmodule : psr_ramp
`default_nettype wire

/* dv/psr_host.sv */
// Fieldbus host model that issues parameter reads and writes.
`timescale 1ns/100ps
`default_nettype none
module psr_host (
	// Parameter bus
	input  wire logic        clk_in,
	input  wire logic        ack_in,
	input  wire logic        err_in,
	input  wire logic [31:0] rdata_in,
	output logic             wr_out,
	output logic             rd_out,
	output logic [11:0]      addr_out,
	output logic [31:0]      wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 12'h0000;
		wdata_out = 32'h0000_0000;
	end
	// Released address and data lines show the inverse of the last value, so stale data is never mistaken for valid.
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic e, output logic [31:0] q);
		@(posedge clk_in) #1;
		wr_out = w;
		rd_out = !w;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in) #1;
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
		e = ack_in ? err_in : 1'bx;
		q = rdata_in;
	endtask : acc
endmodule : psr_host
`default_nettype wire

/* dv/psr_top_bench.sv */
// Self-checking bench of the position scaling and ramp block.
`timescale 1ns/100ps
`default_nettype none
module psr_top_bench;
	// A short control cycle keeps the ramp runs brief.
	localparam int CYC = 20;
	logic        clk = 1'b0, rst_n_in = 1'b0, amp = 1'b0, start = 1'b0;
	logic        wr, rd, ack, err, cdone, reached, limited;
	logic [11:0] addr;
	logic [2:0]  mode = psr_pkg::MODE_PROF_VEL;
	logic [31:0] wdata, rdata, tint, spd, tpos = 32'h0, tspd = 32'h0, apos = 32'h0;
	int          n_errors = 0, total_checks = 0;
	always #2 clk = ~clk;
	psr_host i_host (.clk_in(clk), .ack_in(ack), .err_in(err), .rdata_in(rdata),
		.wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
	psr_top #(.CTRL_CYCLE_CLK(CYC)) i_dut (.clk_in(clk), .rst_n_in(rst_n_in),
		.par_wr_in(wr), .par_rd_in(rd), .par_addr_in(addr), .par_wdata_in(wdata),
		.par_rdata_out(rdata), .par_ack_out(ack), .par_err_out(err),
		.amp_enable_in(amp), .mode_in(mode), .start_in(start), .target_pos_in(tpos),
		.target_speed_in(tspd), .actual_pos_in(apos), .target_int_out(tint),
		.conv_done_out(cdone), .speed_set_out(spd), .reached_out(reached),
		.limited_out(limited));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic xe, input logic [31:0] x);
		logic        e;
		logic [31:0] q;
		i_host.acc(w, a, d, e, q);
		chk("bus err", {31'h0, e}, {31'h0, xe});
		if (!w && !xe) chk("read data", q, x);
	endtask : acc
	task automatic set_amp(input logic v);
		amp = v;
		repeat (4) @(posedge clk);
		#1;
	endtask : set_amp
	task automatic wait_spd(input logic [31:0] x, input int n);
		for (int k = 0; k < n && spd !== x; k++) @(posedge clk) #1;
		chk("speed", spd, x);
	endtask : wait_spd
	task automatic conv(input logic [31:0] u, input logic [31:0] x, input logic l);
		tpos = u;
		start = 1'b1;
		@(posedge clk) #1 start = 1'b0;
		for (int k = 0; k < 200 && cdone !== 1'b1; k++) @(posedge clk) #1;
		chk("conv done", {31'h0, cdone}, 32'h0000_0001);
		@(posedge clk) #1;
		chk("target", tint, x);
		chk("limited", {31'h0, limited}, {31'h0, l});
	endtask : conv
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs();
		logic [11:0] a [5] = '{psr_pkg::OFS_SCALE_DEN, psr_pkg::OFS_SCALE_NUM,
			psr_pkg::OFS_SPEED_LIMIT, psr_pkg::OFS_RAMP_ACC, psr_pkg::OFS_RAMP_DEC};
		logic [31:0] v [5] = '{32'h0000_4000, 32'h0000_0001, 32'h0000_3390,
			32'h0000_0258, 32'h0000_02EE};
		for (int i = 0; i < 5; i++) acc(1'b0, a[i], 0, 1'b0, v[i]);
		acc(1'b0, 12'h0700, 0, 1'b1, 0);
		acc(1'b1, 12'h0700, 1, 1'b1, 0);
		acc(1'b1, psr_pkg::OFS_RAMP_ACC, 32'h0000_001D, 1'b1, 0);
		acc(1'b1, psr_pkg::OFS_RAMP_ACC, 32'h002D_C6C1, 1'b1, 0);
		acc(1'b1, psr_pkg::OFS_RAMP_ACC, 32'h0000_001E, 1'b0, 0);
		acc(1'b0, psr_pkg::OFS_RAMP_ACC, 0, 1'b0, 32'h0000_001E);
		acc(1'b1, psr_pkg::OFS_RAMP_ACC, 32'h0000_0258, 1'b0, 0);
		acc(1'b1, psr_pkg::OFS_RAMP_DEC, 32'h0000_02ED, 1'b1, 0);
		acc(1'b1, psr_pkg::OFS_SPEED_LIMIT, 32'h0000_3391, 1'b1, 0);
		acc(1'b1, psr_pkg::OFS_SPEED_LIMIT, 32'h0000_003B, 1'b1, 0);
		acc(1'b1, psr_pkg::OFS_SCALE_NUM, 32'h0000_0000, 1'b1, 0);
	endtask : t_regs
	task automatic t_scale();
		logic [31:0] t [4][4] = '{'{32'h0000_1000, 1, 1, 32'h0000_0020},
			'{32'h0002_0000, 1, 5, 5}, '{32'h0000_0457, 3, 900, 32'h0004_DC48},
			'{1, 1, 32'h7FFF_FFFF, 32'h7FFF_FFFF}};
		set_amp(1'b1);
		conv(1, 32'h0000_0008, 1'b0);
		acc(1'b1, psr_pkg::OFS_SCALE_DEN, 32'h0000_1000, 1'b1, 0);
		set_amp(1'b0);
		acc(1'b1, psr_pkg::OFS_SCALE_DEN, 32'h0000_1000, 1'b0, 0);
		set_amp(1'b1);
		conv(1, 32'h0000_0008, 1'b0);
		for (int i = 0; i < 4; i++) begin
			set_amp(1'b0);
			acc(1'b1, psr_pkg::OFS_SCALE_DEN, t[i][0], 1'b0, 0);
			acc(1'b1, psr_pkg::OFS_SCALE_NUM, t[i][1], 1'b0, 0);
			set_amp(1'b1);
			conv(t[i][2], t[i][3], i == 3);
		end
	endtask : t_scale
	task automatic t_ramp();
		tspd = 32'h0000_0002;
		conv(0, 0, 1'b0);
		for (int i = 1; i <= 3; i++) wait_spd(600 * i, 2 * CYC + 4);
		wait_spd(32'h0000_07D0, 2 * CYC + 4);
		tspd = 32'hFFFF_FFFE;
		conv(0, 0, 1'b0);
		wait_spd(32'hFFFF_F830, 10 * CYC);
		acc(1'b1, psr_pkg::OFS_SPEED_LIMIT, 32'h0000_003C, 1'b0, 0);
		mode = psr_pkg::MODE_JOG;
		tspd = 32'h0000_0064;
		conv(0, 0, 1'b0);
		wait_spd(32'h0000_EA60, 110 * CYC);
		repeat (3 * CYC) @(posedge clk);
		#1;
		chk("clamped", spd, 32'h0000_EA60);
	endtask : t_ramp
	task automatic t_pos();
		set_amp(1'b0);
		wait_spd(0, 90 * CYC);
		start = 1'b1;
		@(posedge clk) #1 start = 1'b0;
		acc(1'b0, psr_pkg::OFS_STATUS, 0, 1'b0, 32'h0000_0000);
		mode = psr_pkg::MODE_PROF_POS;
		apos = 32'h0002_0005;
		set_amp(1'b1);
		conv(1, 32'h0002_0000, 1'b0);
		for (int k = 0; k < 4 * CYC && reached !== 1'b1; k++) @(posedge clk) #1;
		chk("reached", {31'h0, reached}, 32'h0000_0001);
		chk("still", spd, 0);
		acc(1'b0, psr_pkg::OFS_STATUS, 0, 1'b0, 32'h0000_000A);
	endtask : t_pos
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_n_in = 1'b1;
		t_regs();
		t_scale();
		t_ramp();
		t_pos();
		print_verdict();
	end
	initial begin
		#(CYC * 4000);
		n_errors++;
		print_verdict();
	end
endmodule : psr_top_bench
`default_nettype wire
